//--- verilog/tsc_pkg.sv
// Purpose: Shared constants for the trigger, status and self-test command block
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Notes on behaviour follow
//
// Notes on behaviour
// [RULE1] Status query returns byte, clears nothing
// [RULE2] Bit 6 of query carries master summary
// [RULE3] Serial poll bit 6 is request flag, cleared
// [RULE4] Status byte zeroed only by explicit clearing
// [RULE5] Trigger needs armed, bus source, waiting flag
// [RULE6] Arm by continuous setting or single initiate
// [RULE7] Unarmed trigger: no trigger, no error
// [RULE8] Trigger applies trigger levels, clears waiting flag
// [RULE9] Continuous arm re-arms and sets waiting flag
// [RULE10] Trigger executes only when addressed as listener
// [RULE11] Output off: every bus trigger ignored
// [RULE12] Self test returns zero or failure code
// [RULE13] All subtests run; each failure sets bit
// [RULE14] Codes: ROM 1, RAM 2, storage 4, analog 16
// [RULE15] Codes 32, 64, 128 only under extended query
// [RULE16] Wait command holds later commands until complete
// [RULE17] Pending flag clears on settled and queue empty
package tsc_pkg;
  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int SummaryBit = 6;
  localparam int WaitTrigBit = 5;
  localparam logic [7:0] StatusEnMask = 8'h00BF;
  // ----------------------------------------
  // Self test
  // ----------------------------------------
  localparam int NumSubtests = 7;
  localparam logic [7:0] BasicMask = 8'h0017;
  localparam logic [7:0] ExtMask = 8'h00F7;
  localparam logic [7:0] CodeReset = 8'h0000;
  localparam logic [7:0] LevelReset = 8'h0000;
  // Cycles given to each subtest to report
  localparam int SubtestCycles = 4;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    TSC_CMD_NONE, TSC_CMD_STB, TSC_CMD_POLL, TSC_CMD_TRG,
    TSC_CMD_INIT, TSC_CMD_TST, TSC_CMD_DIAG, TSC_CMD_WAI
  } tsc_cmd_t;
endpackage

//--- verilog/tsc_trigger.sv
// Purpose: Arm and fire logic for the bus trigger
// Assumes: Commands arrive as one-cycle pulses
// Notes: Waiting flag equals armed state
`timescale 1ns/1ps
`default_nettype none
module tsc_trigger (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clockEn,
  // Control
  input  wire logic initPulse,
  input  wire logic trgPulse,
  input  wire logic continuousArmSetting,
  input  wire logic triggerSourceBus,
  input  wire logic listenerAddressed,
  input  wire logic outputOn,
  // Result
  output logic      fire,
  output logic      waitingForTriggerFlag
);
  logic armedReg;
  logic armedNext;
  logic fireNext;
  logic fireReg;

  always_comb begin
    armedNext = armedReg;
    fireNext = 1'b0;
    if (continuousArmSetting || initPulse) begin
      armedNext = 1'b1; // see [RULE6]
    end
    // Unarmed or ignored triggers do nothing and log nothing
    if (trgPulse && armedReg && triggerSourceBus && listenerAddressed && outputOn) begin
      fireNext = 1'b1; // see [RULE5] see [RULE10] see [RULE11] see [RULE7]
      armedNext = continuousArmSetting; // see [RULE8] see [RULE9]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      armedReg <= 1'b0;
      fireReg <= 1'b0;
    end else if (clockEn) begin
      armedReg <= armedNext;
      fireReg <= fireNext;
    end
  end

  assign fire = fireReg;
  assign waitingForTriggerFlag = armedReg;
endmodule
`default_nettype wire

//--- verilog/tsc_selftest.sv
// Purpose: Sequences the subtests and collects the error code
// Assumes: Subtest fail inputs valid while the step is selected
// Notes: Every subtest runs; failure never stops the walk
`timescale 1ns/1ps
`default_nettype none
module tsc_selftest (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clockEn,
  // Start
  input  wire logic       startBasic,
  input  wire logic       startExt,
  // Subtests
  input  wire logic [7:0] subtestFail,
  output logic [7:0]      subtestSelect,
  // Result
  output logic            busy,
  output logic            done,
  output logic [7:0]      code
);
  logic [7:0] maskReg, maskNext, codeReg, codeNext, selReg, selNext;
  logic [1:0] cntReg, cntNext;
  logic       busyReg, busyNext, doneReg, doneNext;

  always_comb begin
    maskNext = maskReg;
    codeNext = codeReg;
    selNext = selReg;
    cntNext = cntReg;
    busyNext = busyReg;
    doneNext = 1'b0;
    if (!busyReg && (startBasic || startExt)) begin
      maskNext = startExt ? tsc_pkg::ExtMask : tsc_pkg::BasicMask; // see [RULE15]
      codeNext = tsc_pkg::CodeReset;
      selNext = 8'h0001;
      cntNext = 2'h0;
      busyNext = 1'b1;
    end else if (busyReg) begin
      cntNext = cntReg + 2'h1;
      if (cntReg == 2'(tsc_pkg::SubtestCycles - 1)) begin
        // Only enabled bits can fail; bit 3 is never a subtest
        codeNext = codeReg | (subtestFail & selReg & maskReg); // see [RULE13] see [RULE14]
        selNext = {selReg[6:0], 1'b0};
        if (selReg[7]) begin
          busyNext = 1'b0;
          doneNext = 1'b1; // see [RULE12]
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      maskReg <= 8'h0000;
      codeReg <= tsc_pkg::CodeReset;
      selReg <= 8'h0000;
      cntReg <= 2'h0;
      busyReg <= 1'b0;
      doneReg <= 1'b0;
    end else if (clockEn) begin
      maskReg <= maskNext;
      codeReg <= codeNext;
      selReg <= selNext;
      cntReg <= cntNext;
      busyReg <= busyNext;
      doneReg <= doneNext;
    end
  end

  assign subtestSelect = selReg & maskReg;
  assign busy = busyReg;
  assign done = doneReg;
  assign code = codeReg;
endmodule
`default_nettype wire

//--- verilog/tsc_top.sv
// Purpose: Command interpreter for status, trigger, self test and wait
// Assumes: One command pulse at a time while cmdReady is high
// Notes: Wait holds cmdReady low until nothing is pending
`timescale 1ns/1ps
`default_nettype none
module tsc_top (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 clockEn,
  // Command port
  input  wire logic                 cmdValid,
  input  wire tsc_pkg::tsc_cmd_t    cmdCode,
  output logic                      cmdReady,
  // Status sources
  input  wire logic [7:0]           statusEvents,
  input  wire logic [7:0]           serviceEnable,
  // Trigger configuration
  input  wire logic                 continuousArmSetting,
  input  wire logic                 triggerSourceBus,
  input  wire logic                 listenerAddressed,
  input  wire logic                 outputOn,
  input  wire logic [15:0]          triggerLevelVoltage,
  input  wire logic [15:0]          triggerLevelCurrent,
  // Pending work
  input  wire logic                 outputSettled,
  input  wire logic                 queueEmpty,
  // Subtests
  input  wire logic [7:0]           subtestFail,
  output logic [7:0]                subtestSelect,
  // Responses
  output logic                      respValid,
  output logic [7:0]                respData,
  // Output levels and flags
  output logic                      levelLoad,
  output logic [15:0]               levelVoltage,
  output logic [15:0]               levelCurrent,
  output logic                      waitingForTriggerFlag,
  output logic                      pendingFlag
);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic isCmd(input logic v, input tsc_pkg::tsc_cmd_t c,
                                 input tsc_pkg::tsc_cmd_t want);
    isCmd = v && (c == want);
  endfunction

  typedef enum logic [1:0] {TSC_IDLE, TSC_TEST, TSC_HOLD} tsc_state_t;

  tsc_state_t stateReg, stateNext;
  logic       take;
  logic       trgPulse, initPulse, fire, armFlag, stDone;
  logic [7:0] stCode, stSel;
  logic       reqReg, reqNext, summary;
  logic [7:0] statusByte;
  logic       respValidReg, respValidNext, levelLoadReg, levelLoadNext;
  logic [7:0] respDataReg, respDataNext;
  logic [15:0] voltReg, voltNext, currReg, currNext;
  logic       pendReg, pendNext, waitFlagReg, readyReg, readyNext;
  logic [7:0] selReg;

  assign take = cmdValid && readyReg && clockEn;
  assign trgPulse = take && isCmd(cmdValid, cmdCode, tsc_pkg::TSC_CMD_TRG);
  assign initPulse = take && isCmd(cmdValid, cmdCode, tsc_pkg::TSC_CMD_INIT);

  tsc_trigger uTrig (
    .clock                (clock),
    .rst                  (rst),
    .clockEn              (clockEn),
    .initPulse            (initPulse),
    .trgPulse             (trgPulse),
    .continuousArmSetting (continuousArmSetting),
    .triggerSourceBus     (triggerSourceBus),
    .listenerAddressed    (listenerAddressed),
    .outputOn             (outputOn),
    .fire                 (fire),
    .waitingForTriggerFlag(armFlag)
  );

  tsc_selftest uTest (
    .clock        (clock),
    .rst          (rst),
    .clockEn      (clockEn),
    .startBasic   (take && isCmd(cmdValid, cmdCode, tsc_pkg::TSC_CMD_TST)),
    .startExt     (take && isCmd(cmdValid, cmdCode, tsc_pkg::TSC_CMD_DIAG)),
    .subtestFail  (subtestFail),
    .subtestSelect(stSel),
    .busy         (),
    .done         (stDone),
    .code         (stCode)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  // Live view of the sources; no read here ever clears them
  assign summary = |(statusEvents & serviceEnable & tsc_pkg::StatusEnMask); // see [RULE2]
  assign statusByte = statusEvents & tsc_pkg::StatusEnMask; // see [RULE4]

  always_comb begin
    stateNext = stateReg;
    readyNext = readyReg;
    reqNext = reqReg;
    respValidNext = 1'b0;
    respDataNext = respDataReg;
    levelLoadNext = 1'b0;
    voltNext = voltReg;
    currNext = currReg;
    pendNext = !(outputSettled && queueEmpty); // see [RULE17]
    // Request flag sets whenever summary is high and stays set until dropped by the poll
    if (summary && !reqReg) begin
      reqNext = 1'b1;
    end
    if (fire) begin
      voltNext = triggerLevelVoltage; // see [RULE8]
      currNext = triggerLevelCurrent;
      levelLoadNext = 1'b1;
    end
    case (stateReg)
      TSC_IDLE: begin
        if (take) begin
          case (cmdCode)
            tsc_pkg::TSC_CMD_STB: begin
              respValidNext = 1'b1;
              respDataNext = statusByte;
              respDataNext[tsc_pkg::SummaryBit] = summary; // see [RULE1] see [RULE2]
            end
            tsc_pkg::TSC_CMD_POLL: begin
              respValidNext = 1'b1;
              respDataNext = statusByte;
              respDataNext[tsc_pkg::SummaryBit] = reqReg; // see [RULE3]
              reqNext = 1'b0; // see [RULE3]
            end
            tsc_pkg::TSC_CMD_TST, tsc_pkg::TSC_CMD_DIAG: begin
              stateNext = TSC_TEST;
              readyNext = 1'b0;
            end
            tsc_pkg::TSC_CMD_WAI: begin
              stateNext = TSC_HOLD; // see [RULE16]
              readyNext = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      TSC_TEST: begin
        if (stDone) begin
          respValidNext = 1'b1;
          respDataNext = stCode; // see [RULE12]
          stateNext = TSC_IDLE;
          readyNext = 1'b1;
        end
      end
      TSC_HOLD: begin
        // Released only once no operation or level change is pending
        if (!pendReg && !fire && !levelLoadReg) begin
          stateNext = TSC_IDLE; // see [RULE16] see [RULE17]
          readyNext = 1'b1;
        end
      end
      default: begin
        stateNext = TSC_IDLE;
        readyNext = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stateReg <= TSC_IDLE;
      readyReg <= 1'b1;
      reqReg <= 1'b0;
      respValidReg <= 1'b0;
      respDataReg <= 8'h0000;
      levelLoadReg <= 1'b0;
      voltReg <= 16'h0000;
      currReg <= 16'h0000;
      pendReg <= 1'b0;
      waitFlagReg <= 1'b0;
      selReg <= 8'h0000;
    end else if (clockEn) begin
      stateReg <= stateNext;
      readyReg <= readyNext;
      reqReg <= reqNext;
      respValidReg <= respValidNext;
      respDataReg <= respDataNext;
      levelLoadReg <= levelLoadNext;
      voltReg <= voltNext;
      currReg <= currNext;
      pendReg <= pendNext;
      waitFlagReg <= armFlag;
      selReg <= stSel;
    end
  end

  assign cmdReady = readyReg;
  assign respValid = respValidReg;
  assign respData = respDataReg;
  assign levelLoad = levelLoadReg;
  assign levelVoltage = voltReg;
  assign levelCurrent = currReg;
  assign waitingForTriggerFlag = waitFlagReg;
  assign pendingFlag = pendReg;
  assign subtestSelect = selReg;
endmodule
`default_nettype wire

//--- testbench/tsc_checker.sv
// Purpose: Port assertions for the command block
// Assumes: One clock, sync active-high reset
// Notes: Bound to the top module after endmodule
`timescale 1ns/1ps
`default_nettype none
module tsc_checker (
  // Clock, reset, command
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              clockEn,
  input wire logic              cmdValid,
  input wire tsc_pkg::tsc_cmd_t cmdCode,
  input wire logic              cmdReady,
  // Sources
  input wire logic [7:0]        statusEvents,
  input wire logic [7:0]        serviceEnable,
  input wire logic              continuousArmSetting,
  input wire logic              triggerSourceBus,
  input wire logic              listenerAddressed,
  input wire logic              outputOn,
  input wire logic [15:0]       triggerLevelVoltage,
  input wire logic              outputSettled,
  input wire logic              queueEmpty,
  // Results
  input wire logic [7:0]        subtestSelect,
  input wire logic              respValid,
  input wire logic [7:0]        respData,
  input wire logic              levelLoad,
  input wire logic [15:0]       levelVoltage,
  input wire logic              waitingForTriggerFlag,
  input wire logic              pendingFlag
);
  wire logic take = cmdValid && cmdReady && clockEn;
  logic basic_reg;
  logic basic_next;
  // Remembers which test kind ran last, since select trails the take
  always_comb begin
    basic_next = basic_reg;
    if (take && cmdCode == tsc_pkg::TSC_CMD_TST) basic_next = 1'b1;
    if (take && cmdCode == tsc_pkg::TSC_CMD_DIAG) basic_next = 1'b0;
  end
  always_ff @(posedge clock) basic_reg <= rst ? 1'b0 : basic_next;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_stb;
    take && cmdCode == tsc_pkg::TSC_CMD_STB |=> respValid && respData == {$past(statusEvents[7]),
      |($past(statusEvents) & $past(serviceEnable) & 8'hbf), $past(statusEvents[5:0])};
  endproperty
  a_stb: assert property (p_stb) else $error("status reply wrong");
  property p_poll;
    take && cmdCode == tsc_pkg::TSC_CMD_POLL |=> respValid
      && (respData & 8'hbf) == ($past(statusEvents) & 8'hbf);
  endproperty
  a_poll: assert property (p_poll) else $error("poll reply wrong");
  property p_nofire;
    take && cmdCode == tsc_pkg::TSC_CMD_TRG
      && !(outputOn && listenerAddressed && triggerSourceBus) |-> ##2 !levelLoad;
  endproperty
  a_nofire: assert property (p_nofire) else $error("trigger not gated");
  property p_lvl;
    levelLoad |-> levelVoltage == $past(triggerLevelVoltage);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not applied");
  property p_cont;
    continuousArmSetting && $past(continuousArmSetting) && $past(continuousArmSetting, 2)
      && !$past(rst) && !$past(rst, 2) |-> waitingForTriggerFlag;
  endproperty
  a_cont: assert property (p_cont) else $error("not re-armed");
  property p_sel;
    (subtestSelect & (basic_reg ? 8'he8 : 8'h08)) == 8'h00;
  endproperty
  a_sel: assert property (p_sel) else $error("subtest out of set");
  property p_pend;
    !$past(rst) |-> pendingFlag == !($past(outputSettled) && $past(queueEmpty));
  endproperty
  a_pend: assert property (p_pend) else $error("pending flag wrong");
  property p_wai;
    take && cmdCode == tsc_pkg::TSC_CMD_WAI && pendingFlag |=> !cmdReady;
  endproperty
  a_wai: assert property (p_wai) else $error("wait not held");
endmodule
bind tsc_top tsc_checker u_tsc_checker (.clock(clock), .rst(rst), .clockEn(clockEn),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReady(cmdReady), .statusEvents(statusEvents),
  .serviceEnable(serviceEnable), .continuousArmSetting(continuousArmSetting),
  .triggerSourceBus(triggerSourceBus), .listenerAddressed(listenerAddressed),
  .outputOn(outputOn), .triggerLevelVoltage(triggerLevelVoltage), .outputSettled(outputSettled),
  .queueEmpty(queueEmpty), .subtestSelect(subtestSelect), .respValid(respValid),
  .respData(respData), .levelLoad(levelLoad), .levelVoltage(levelVoltage),
  .waitingForTriggerFlag(waitingForTriggerFlag), .pendingFlag(pendingFlag));
`default_nettype wire

//--- testbench/tsc_subtest_model.sv
// Purpose: Stand-in for the subtest hardware
// Assumes: One subtest selected at a time
// Notes: Idle lines toggle so stale data never reads as a result
`timescale 1ns/1ps
`default_nettype none
module tsc_subtest_model (
  // Clock
  input  wire logic       clock,
  // Subtest lines
  input  wire logic [7:0] failPattern,
  input  wire logic [7:0] subtestSelect,
  output logic [7:0]      subtestFail
);
  logic [7:0] idle_reg = 8'ha5;
  wire logic [7:0] idle_next = ~idle_reg;
  always_ff @(posedge clock) idle_reg <= idle_next;
  // Each step reports only its own error bit
  assign subtestFail = (subtestSelect != 8'h00) ? (failPattern & subtestSelect) : idle_reg;
endmodule
`default_nettype wire

//--- testbench/test_trigger_status_selftest_cmds.sv
// Purpose: Self-checking bench for the command block
// Assumes: Fixed seed, clock enable held high
// Notes: Subtest side is a separate model
`timescale 1ns/1ps
`default_nettype none
module test_trigger_status_selftest_cmds;
  logic clock = 1'b0, rst = 1'b1, cmdValid = 1'b0, arm = 1'b0, srcBus = 1'b0;
  logic lsn = 1'b0, outOn = 1'b0, settled = 1'b1, qEmpty = 1'b1, armed, fired, exp;
  logic [7:0] ev = '0, en = '0, failPat = '0, e, m, sel, fail, rdata;
  logic [15:0] volt = '0, curr = '0, lv, lc;
  logic cmdReady, respValid, levelLoad, waitFlag, pendingFlag;
  logic [31:0] r;
  tsc_pkg::tsc_cmd_t cmdCode = tsc_pkg::TSC_CMD_NONE;
  integer seed = 32'h0000_ab86, failures = 0, num_checks = 0;
  tsc_top u_tsc_top (.clock(clock), .rst(rst), .clockEn(1'b1), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdReady(cmdReady), .statusEvents(ev), .serviceEnable(en),
    .continuousArmSetting(arm), .triggerSourceBus(srcBus), .listenerAddressed(lsn),
    .outputOn(outOn), .triggerLevelVoltage(volt), .triggerLevelCurrent(curr),
    .outputSettled(settled), .queueEmpty(qEmpty), .subtestFail(fail), .subtestSelect(sel),
    .respValid(respValid), .respData(rdata), .levelLoad(levelLoad), .levelVoltage(lv),
    .levelCurrent(lc), .waitingForTriggerFlag(waitFlag), .pendingFlag(pendingFlag));
  tsc_subtest_model u_tsc_subtest_model (.clock(clock), .failPattern(failPat),
    .subtestSelect(sel), .subtestFail(fail));
  always #5 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH %0t seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bail;
    failures++;
    end_sim();
  endtask
  // Gap of one edge before each request keeps valid from being driven twice in a step
  task automatic send(input tsc_pkg::tsc_cmd_t c);
    int n;
    n = 0;
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdCode <= c;
    do begin
      @(posedge clock);
      n++;
    end while (cmdReady !== 1'b1 && n < 200);
    cmdValid <= 1'b0;
    if (n >= 200) bail();
  endtask
  task automatic getResp(input logic [7:0] want);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (respValid !== 1'b1 && n < 100);
    if (n >= 100) bail();
    check(rdata, want);
  endtask
  task automatic trg;
    send(tsc_pkg::TSC_CMD_TRG);
    fired = 1'b0;
    repeat (3) begin
      @(posedge clock);
      fired = fired | levelLoad;
    end
  endtask
  function automatic logic [7:0] expStat(input logic [7:0] x, input logic [7:0] y);
    return {x[7], |(x & y & 8'hbf), x[5:0]};
  endfunction
  initial begin
    repeat (20000) @(posedge clock);
    bail();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      e = (i == 0) ? 8'h40 : r[7:0];
      m = (i == 0) ? 8'hff : r[15:8];
      ev <= e;
      en <= m;
      settled <= r[16];
      qEmpty <= r[17];
      send(tsc_pkg::TSC_CMD_STB);
      getResp(expStat(e, m));
    end
    ev <= 8'h01;
    en <= 8'h01;
    repeat (3) @(posedge clock);
    ev <= 8'h00;
    send(tsc_pkg::TSC_CMD_STB);
    getResp(8'h00);
    send(tsc_pkg::TSC_CMD_POLL);
    getResp(8'h40);
    send(tsc_pkg::TSC_CMD_POLL);
    getResp(8'h00);
    armed = 1'b0;
    for (int i = 0; i < 20; i++) begin
      r = (i == 0) ? 32'h1234_000f : (i == 1) ? 32'h0000_0007 : $random(seed);
      {srcBus, lsn, outOn} <= r[2:0];
      volt <= r[31:16];
      curr <= r[15:0];
      if (r[3]) begin
        send(tsc_pkg::TSC_CMD_INIT);
        armed = 1'b1;
        repeat (2) @(posedge clock);
      end
      trg();
      exp = armed && (r[2:0] == 3'h7);
      check(fired, exp);
      if (exp) check(lv, r[31:16]);
      if (exp) check(lc, r[15:0]);
      armed = armed && !exp;
      check(waitFlag, armed);
    end
    arm <= 1'b1;
    {srcBus, lsn, outOn} <= 3'h7;
    repeat (3) @(posedge clock);
    repeat (2) begin
      trg();
      check(fired, 1'b1);
      check(waitFlag, 1'b1);
    end
    arm <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      e = (k < 2) ? 8'hff : (k == 2) ? 8'h00 : r[7:0];
      failPat <= e;
      send(k[0] ? tsc_pkg::TSC_CMD_DIAG : tsc_pkg::TSC_CMD_TST);
      getResp(e & (k[0] ? 8'hf7 : 8'h17));
    end
    settled <= 1'b0;
    qEmpty <= 1'b1;
    repeat (2) @(posedge clock);
    send(tsc_pkg::TSC_CMD_WAI);
    repeat (5) @(posedge clock);
    check(cmdReady, 1'b0);
    check(pendingFlag, 1'b1);
    settled <= 1'b1;
    send(tsc_pkg::TSC_CMD_STB);
    getResp(8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
